// >>> design/utf_top.sv
// The register offsets and register access over Wishbone are this design's own decisions.
`default_nettype none
// How it works
// (RULE1) NRZ: mark drives high, space drives low
// (RULE2) No character starts until clear-to-send low
// (RULE3) Negated clear-to-send: finish character, then hold
// (RULE4) Clear-to-send sampled per bit; toggle sets flag
// (RULE5) Ignore-flow bit sends whenever FIFO has data
// (RULE6) Clear-to-send change interrupts on either edge
// (RULE7) Far end gives receive pulses; polarity bit
// (RULE8) Request-to-send low ready, high nearly full
// (RULE9) Otherwise request-to-send follows software bit
// (RULE10) Shared clock pin: input or bit clock
// (RULE11) Empty FIFO gives idle line level
// (RULE12) Start, data LSB first, parity, stop
// (RULE13) Parity bit follows most significant data bit
// (RULE14) New bit at falling bit clock edge
// (RULE15) Slot-free status; writes dropped when full
// (RULE16) Empty interrupt once per emptying
// (RULE17) Half interrupt from fill or level marker
// (RULE18) Send-break drives continuous zeros
// (RULE19) Software break procedure waits on busy
// (RULE20) Transmit disable flushes FIFO, current finishes
// (RULE21) Busy holds until last character sent
// (RULE22) Infrared zero is 3/16 bit pulse
// (RULE23) Transmit polarity selects pulse and idle
// (RULE24) Parity inject sends wrong parity
module utf_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire utf_pkg::utf_wb_req_t wb_req,
  output utf_pkg::utf_wb_rsp_t wb_rsp,
  input wire logic cts_b,
  input wire logic rx_nearly_full,
  input wire logic ucl_in,
  output logic txd,
  output logic rts_b,
  output logic ucl_out,
  output logic ucl_oe_b,
  output logic rx_pulse_polarity,
  output logic irq
);

  // ==========================================================
  // Bus slave
  logic ack_q;
  logic [31:0] rdat_q;
  logic access;
  logic wr;
  logic [31:0] wmask;
  logic [15:0] ctrl_q;
  logic [15:0] misc_q;
  logic [15:0] baud_q;
  logic [15:0] level_q;
  logic brk_q;
  logic ign_q;
  logic cts_s_q;
  logic delta_q;
  logic empty_evt_q;
  logic [6:0] cnt_q;
  utf_pkg::utf_state_t st_q;
  logic busy;
  logic avail;
  logic half;
  logic push;

  assign access = wb_req.cyc && wb_req.stb && !ack_q;
  assign wr = access && wb_req.we;
  assign wmask = {{8{wb_req.sel[3]}}, {8{wb_req.sel[2]}}, {8{wb_req.sel[1]}},
                  {8{wb_req.sel[0]}}};

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= access;
      rdat_q <= 32'h0000_0000;
      if (access && !wb_req.we)
      begin
        unique case (wb_req.adr)
          utf_pkg::ADR_CTRL: rdat_q <= {16'h0000, ctrl_q};
          utf_pkg::ADR_TX: rdat_q <= {16'h0000, empty_evt_q, cnt_q == 7'h00, ign_q, brk_q,
                                      delta_q, cts_s_q, busy, avail, 8'h00};
          utf_pkg::ADR_MISC: rdat_q <= {16'h0000, misc_q};
          utf_pkg::ADR_BAUD: rdat_q <= {16'h0000, baud_q};
          utf_pkg::ADR_LEVEL: rdat_q <= {9'h000, cnt_q, level_q};
          default: rdat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_comb
  begin
    wb_rsp.ack = ack_q;
    wb_rsp.dat = rdat_q;
  end

  // ==========================================================
  // Control registers
  logic port_en;
  logic tx_en;
  logic irda;
  logic tx_pol;
  logic tx_en_clear;

  assign port_en = ctrl_q[utf_pkg::C_PORT_EN];
  assign tx_en = ctrl_q[utf_pkg::C_TX_EN];
  assign irda = ctrl_q[utf_pkg::C_IRDA];
  assign tx_pol = misc_q[utf_pkg::M_TX_POL];
  assign tx_en_clear = wr && wb_req.adr == utf_pkg::ADR_CTRL && wb_req.sel[0]
                       && !wb_req.dat[utf_pkg::C_TX_EN];

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl_q <= utf_pkg::CTRL_RST;
      misc_q <= utf_pkg::MISC_RST;
      baud_q <= utf_pkg::BAUD_RST;
      level_q <= utf_pkg::LEVEL_RST;
      brk_q <= 1'b0;
      ign_q <= 1'b0;
    end
    else if (wr)
    begin
      unique case (wb_req.adr)
        utf_pkg::ADR_CTRL: ctrl_q <= (ctrl_q & ~wmask[15:0]) | (wb_req.dat[15:0] & wmask[15:0]);
        utf_pkg::ADR_MISC: misc_q <= (misc_q & ~wmask[15:0]) | (wb_req.dat[15:0] & wmask[15:0]);
        utf_pkg::ADR_BAUD: baud_q <= (baud_q & ~wmask[15:0]) | (wb_req.dat[15:0] & wmask[15:0]);
        utf_pkg::ADR_LEVEL: level_q <= (level_q & ~wmask[15:0]) | (wb_req.dat[15:0] & wmask[15:0]);
        utf_pkg::ADR_TX:
        begin
          if (wb_req.sel[1])
          begin
            brk_q <= wb_req.dat[utf_pkg::T_BRK];
            ign_q <= wb_req.dat[utf_pkg::T_IGN];
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Baud divider: one 16x tick, from system clock or pin edge
  logic [15:0] div_q;
  logic ucl_prev_q;
  logic tick16;
  logic [3:0] sub_q;
  logic bit_edge;
  logic ext_src;

  assign ext_src = ctrl_q[utf_pkg::C_BAUD_EXT];
  assign tick16 = port_en && (ext_src ? (ucl_in && !ucl_prev_q) : (div_q == baud_q));
  assign bit_edge = tick16 && sub_q == utf_pkg::SUB_LAST;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      div_q <= 16'h0000;
      ucl_prev_q <= 1'b0;
      sub_q <= 4'h0;
    end
    else
    begin
      ucl_prev_q <= ucl_in;
      div_q <= (tick16 || ext_src || !port_en) ? 16'h0000 : div_q + 16'h0001;
      if (tick16)
        sub_q <= sub_q + 4'h1;
    end
  end

  // Bit clock is high in the second half so it falls where a bit begins
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ucl_out <= 1'b0;
      ucl_oe_b <= 1'b1;
    end
    else
    begin
      ucl_out <= sub_q[3]; // RULE14
      // The pin is released the cycle after it starts feeding the divider
      ucl_oe_b <= !(ctrl_q[utf_pkg::C_CLK_OUT] && !ext_src); // RULE10
    end
  end

  // ==========================================================
  // Clear-to-send sampling
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cts_s_q <= 1'b1;
      delta_q <= 1'b0;
    end
    else
    begin
      if (bit_edge)
        cts_s_q <= cts_b; // RULE4
      // A toggle in the clearing cycle still sets the flag
      if (bit_edge && cts_b != cts_s_q)
        delta_q <= 1'b1; // RULE4 RULE6
      else if (wr && wb_req.adr == utf_pkg::ADR_TX && wb_req.sel[1]
               && wb_req.dat[utf_pkg::T_DELTA])
        delta_q <= 1'b0;
    end
  end

  // ==========================================================
  // Transmit FIFO
  logic [7:0] mem_q [utf_pkg::TX_DEPTH];
  logic [5:0] wp_q;
  logic [5:0] rp_q;
  logic pop;
  logic can_start;
  logic [3:0] nleft_q;

  assign avail = cnt_q != utf_pkg::TX_FULL; // RULE15
  assign push = wr && wb_req.adr == utf_pkg::ADR_TX && wb_req.sel[0] && avail; // RULE15
  assign busy = st_q == utf_pkg::UTF_SHIFT || cnt_q != 7'h00; // RULE21
  assign can_start = cnt_q != 7'h00 && tx_en && (ign_q || !cts_s_q); // RULE2 RULE3 RULE5
  assign pop = bit_edge && can_start && (st_q == utf_pkg::UTF_IDLE || nleft_q == 4'h0);

  generate
    if (utf_pkg::TX_DEPTH == utf_pkg::SMALL_DEPTH)
    begin : g_small
      assign half = cnt_q < utf_pkg::SMALL_HALF; // RULE17
    end
    else
    begin : g_large
      assign half = (utf_pkg::TX_FULL - cnt_q) <= level_q[6:0]; // RULE17
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q] <= wb_req.dat[7:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      wp_q <= 6'h00;
      rp_q <= 6'h00;
      cnt_q <= 7'h00;
    end
    else if (tx_en_clear)
    begin
      // Flush at once; a character already in the shifter carries on
      wp_q <= 6'h00; // RULE20
      rp_q <= 6'h00;
      cnt_q <= 7'h00;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 6'h01;
      if (pop)
        rp_q <= rp_q + 6'h01;
      cnt_q <= cnt_q + {6'h00, push} - {6'h00, pop};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      empty_evt_q <= 1'b0;
    else if (pop && cnt_q == 7'h01 && !push)
      empty_evt_q <= 1'b1; // RULE16
    else if (wr && wb_req.adr == utf_pkg::ADR_TX && wb_req.sel[1]
             && wb_req.dat[utf_pkg::T_EMPTY_EVT])
      empty_evt_q <= 1'b0;
  end

  // ==========================================================
  // Framing
  logic [11:0] frame_d;
  logic [3:0] nbits_d;
  logic [7:0] head;
  logic [7:0] dsel;
  logic par_bit;
  logic char8;
  logic par_en;

  assign char8 = ctrl_q[utf_pkg::C_CHAR8];
  assign par_en = ctrl_q[utf_pkg::C_PAR_EN];
  assign head = mem_q[rp_q];
  assign dsel = char8 ? head : {1'b0, head[6:0]};
  assign par_bit = ^dsel ^ ctrl_q[utf_pkg::C_PAR_ODD] ^ misc_q[utf_pkg::M_PAR_INJ]; // RULE24

  always_comb
  begin
    frame_d = 12'hFFF;
    frame_d[0] = 1'b0; // RULE12
    for (int i = 0; i < 8; i++)
    begin
      if (i < 7 || char8)
        frame_d[i + 1] = dsel[i]; // RULE12
    end
    if (par_en)
      frame_d[char8 ? 9 : 8] = par_bit; // RULE13
    // Shifts after the start bit; one more would add a second stop bit
    nbits_d = 4'h8 + {3'h0, char8} + {3'h0, par_en};
  end

  // ==========================================================
  // Shifter
  logic [11:0] sh_q;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_q <= utf_pkg::UTF_IDLE;
      sh_q <= 12'hFFF;
      nleft_q <= 4'h0;
    end
    else if (bit_edge)
    begin
      if (st_q == utf_pkg::UTF_SHIFT && nleft_q != 4'h0)
      begin
        sh_q <= {1'b1, sh_q[11:1]}; // RULE12
        nleft_q <= nleft_q - 4'h1;
      end
      else if (pop)
      begin
        st_q <= utf_pkg::UTF_SHIFT;
        sh_q <= frame_d;
        nleft_q <= nbits_d;
      end
      else
        st_q <= utf_pkg::UTF_IDLE; // RULE3 RULE11
    end
  end

  // ==========================================================
  // Line coding
  logic bitval;
  logic pulse;
  logic txd_d;

  always_comb
  begin
    bitval = (st_q == utf_pkg::UTF_SHIFT) ? sh_q[0] : 1'b1; // RULE11
    if (brk_q)
      bitval = 1'b0; // RULE18
    pulse = irda && !bitval && sub_q < utf_pkg::IRDA_PULSE_TICKS; // RULE22
    txd_d = irda ? (pulse ^ tx_pol) : bitval; // RULE1 RULE23
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      txd <= 1'b1;
      rts_b <= 1'b1;
      rx_pulse_polarity <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      txd <= txd_d;
      rts_b <= misc_q[utf_pkg::M_RTSFLOW] ? rx_nearly_full : misc_q[utf_pkg::M_RTSGP]; // RULE8 RULE9
      rx_pulse_polarity <= misc_q[utf_pkg::M_RX_POL];
      irq <= (ctrl_q[utf_pkg::C_CTS_IE] && delta_q) // RULE6
             || (ctrl_q[utf_pkg::C_AVAIL_IE] && avail) // RULE15
             || (ctrl_q[utf_pkg::C_EMPTY_IE] && empty_evt_q) // RULE16
             || (ctrl_q[utf_pkg::C_HALF_IE] && half); // RULE17
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_last_pop;
    pop && cnt_q == 7'h01 && !push && !tx_en_clear;
  endsequence

  sequence s_start;
    bit_edge && st_q == utf_pkg::UTF_IDLE && pop;
  endsequence

  AST_CTS_GATE: assert property (s_start |-> (ign_q || !cts_s_q)) // RULE2
    else $error("character started with clear-to-send negated");
  AST_START_BIT: assert property (s_start ##1 (!brk_q && !irda) |=> !txd) // RULE12
    else $error("start bit not low");
  AST_FULL_DROP: assert property ((wr && wb_req.adr == utf_pkg::ADR_TX && cnt_q
                                   == utf_pkg::TX_FULL) |=> cnt_q <= $past(cnt_q)) // RULE15
    else $error("write accepted while FIFO full");
  AST_IDLE_HIGH: assert property ((st_q == utf_pkg::UTF_IDLE && !irda && !brk_q) |=> txd) // RULE11
    else $error("idle line not high");
  AST_BREAK_LOW: assert property ((brk_q && !irda) |=> !txd) // RULE18
    else $error("break not driving zero");
  AST_FLUSH: assert property (tx_en_clear |=> cnt_q == 7'h00) // RULE20
    else $error("FIFO not flushed on transmit disable");
  AST_RTS_FULL: assert property ((misc_q[utf_pkg::M_RTSFLOW] && rx_nearly_full) |=> rts_b) // RULE8
    else $error("request-to-send low while receiver nearly full");
  AST_IRDA_WIDTH: assert property ((irda && sub_q >= utf_pkg::IRDA_PULSE_TICKS) |=> // RULE22
                                   txd == $past(tx_pol))
    else $error("infrared pulse too wide");
  AST_DELTA: assert property ($changed(cts_s_q) |-> delta_q) // RULE4
    else $error("clear-to-send change not flagged");
  AST_EMPTY_EVT: assert property (s_last_pop |=> empty_evt_q) // RULE16
    else $error("empty event not raised");
  AST_BUSY: assert property ((access && !wb_req.we && wb_req.adr == utf_pkg::ADR_TX // RULE21
                              && st_q == utf_pkg::UTF_SHIFT) |=> wb_rsp.dat[utf_pkg::T_BUSY])
    else $error("busy clear while shifting");

endmodule
`default_nettype wire

// >>> design/utf_pkg.sv
`default_nettype none
package utf_pkg;

  // ==========================================================
  // Bus carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } utf_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } utf_wb_rsp_t;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_TX = 8'h04;
  localparam logic [7:0] ADR_MISC = 8'h08;
  localparam logic [7:0] ADR_BAUD = 8'h0C;
  localparam logic [7:0] ADR_LEVEL = 8'h10;

  // ==========================================================
  // port_control_reg fields
  localparam int C_PORT_EN = 0;
  localparam int C_TX_EN = 1;
  localparam int C_IRDA = 2;
  localparam int C_PAR_EN = 3;
  localparam int C_PAR_ODD = 4;
  localparam int C_CTS_IE = 5;
  localparam int C_AVAIL_IE = 6;
  localparam int C_EMPTY_IE = 7;
  localparam int C_HALF_IE = 8;
  localparam int C_CHAR8 = 9;
  localparam int C_CLK_OUT = 10;
  localparam int C_BAUD_EXT = 11;

  // ==========================================================
  // transmit_reg fields
  localparam int T_AVAIL = 8;
  localparam int T_BUSY = 9;
  localparam int T_CTS = 10;
  localparam int T_DELTA = 11;
  localparam int T_BRK = 12;
  localparam int T_IGN = 13;
  localparam int T_EMPTY = 14;
  localparam int T_EMPTY_EVT = 15;

  // ==========================================================
  // misc_control_reg fields
  localparam int M_RX_POL = 0;
  localparam int M_TX_POL = 1;
  localparam int M_RTSGP = 2;
  localparam int M_RTSFLOW = 3;
  localparam int M_PAR_INJ = 4;

  // ==========================================================
  // Reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] MISC_RST = 16'h0000;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [15:0] LEVEL_RST = 16'h0004;

  // ==========================================================
  // FIFO and bit timing
  localparam int TX_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam logic [6:0] TX_FULL = 7'h40;
  localparam int SMALL_DEPTH = 8;
  localparam logic [6:0] SMALL_HALF = 7'h04;
  localparam logic [3:0] SUB_LAST = 4'hF;
  localparam logic [3:0] IRDA_PULSE_TICKS = 4'h3;

  typedef enum logic {UTF_IDLE, UTF_SHIFT} utf_state_t;

endpackage
`default_nettype wire

// >>> tb/utf_far_end.sv
`default_nettype none
module utf_far_end (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic txd,
  input wire logic cts_hold,
  output logic cts_b,
  output logic [9:0] rx_bits,
  output logic [31:0] rx_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Flow control and frame decoder
  // Far end holds clear-to-send low unless told to hold off
  assign cts_b = cts_hold;
  initial rx_count = '0;
  initial rx_bits = '0;
  // Bits are 16 clocks with divisor 0; sampling mid-bit hides edge skew
  always
  begin
    @(posedge clk iff (rst_b === 1'b1 && txd === 1'b0));
    repeat (8) @(posedge clk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (16) @(posedge clk);
      rx_bits[i] = txd;
    end
    rx_count = rx_count + 1;
  end
endmodule
`default_nettype wire

// >>> tb/utf_tx_flow_irda_bench.sv
`default_nettype none
module utf_tx_flow_irda_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cts_hold = 1'b0;
  logic rx_nearly_full = 1'b0;
  utf_pkg::utf_wb_req_t wb_req = '0;
  utf_pkg::utf_wb_rsp_t wb_rsp;
  logic txd, rts_b, cts_b, irq;
  logic ucl_in = 1'b0;
  logic ucl_out, ucl_oe_b, rx_pol;
  logic [9:0] rx_bits;
  logic [31:0] rx_count, q, base, ctl;
  int n_errors = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  utf_top u_utf_top (.clk(clk), .rst_b(rst_b), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .cts_b(cts_b), .rx_nearly_full(rx_nearly_full), .ucl_in(ucl_in), .txd(txd),
    .rts_b(rts_b), .ucl_out(ucl_out), .ucl_oe_b(ucl_oe_b), .rx_pulse_polarity(rx_pol),
    .irq(irq));
  utf_far_end u_utf_far_end (.clk(clk), .rst_b(rst_b), .txd(txd), .cts_hold(cts_hold),
    .cts_b(cts_b), .rx_bits(rx_bits), .rx_count(rx_count));
  // ==========================================================
  // Shared tasks
  function automatic logic [31:0] bit_at(input int i);
    return 32'h1 << i;
  endfunction
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic hang();
    $display("Error wait expected done seen timeout");
    n_errors++;
    print_verdict();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask
  // Classic cycle: hold everything until ack is sampled, then idle a cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_rsp.ack !== 1'b1 && n < 20);
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
    if (n >= 20)
      hang();
  endtask
  task automatic wait_rx(input logic [31:0] t);
    int n;
    n = 0;
    while (rx_count !== t && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 1000)
      hang();
  endtask
  task automatic wait_low();
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 100)
      hang();
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_reset();
    chk("txd idle", txd, 1'b1);
    chk("rts_b", rts_b, 1'b1);
    chk("irq", irq, 1'b0);
    wb(1'b0, utf_pkg::ADR_LEVEL, '0, 4'hF);
    chk("level", q[15:0], utf_pkg::LEVEL_RST);
    wb(1'b0, 8'hFC, '0, 4'hF);
    chk("unmapped", q, '0);
    wb(1'b0, utf_pkg::ADR_TX, '0, 4'hF);
    chk("slot free", q[utf_pkg::T_AVAIL], 1'b1);
  endtask
  task automatic s_frame();
    base = rx_count;
    wb(1'b1, utf_pkg::ADR_CTRL, ctl, 4'hF);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_IGN) | 32'hA5, 4'hF);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_IGN) | 32'h3C, 4'hF);
    wait_rx(base + 1);
    chk("data", rx_bits[7:0], 8'hA5);
    chk("parity", rx_bits[8], ^8'hA5);
    chk("stop", rx_bits[9], 1'b1);
    wait_rx(base + 2);
    chk("data back to back", rx_bits[7:0], 8'h3C);
    wb(1'b1, utf_pkg::ADR_MISC, bit_at(utf_pkg::M_PAR_INJ), 4'hF);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_IGN) | 32'h3C, 4'hF);
    wait_rx(base + 3);
    chk("forced parity", rx_bits[8], ~^8'h3C);
    wb(1'b1, utf_pkg::ADR_MISC, '0, 4'hF);
    wb(1'b1, utf_pkg::ADR_CTRL, (ctl & ~bit_at(utf_pkg::C_CHAR8)) |
      bit_at(utf_pkg::C_PAR_ODD), 4'hF);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_IGN) | 32'h35, 4'hF);
    wait_rx(base + 4);
    chk("seven bit data", rx_bits[6:0], 7'h35);
    chk("odd parity", rx_bits[7], 1'b1);
    chk("seven bit stop", rx_bits[8], 1'b1);
    wb(1'b1, utf_pkg::ADR_CTRL, ctl, 4'hF);
    wb(1'b0, utf_pkg::ADR_TX, '0, 4'hF);
    chk("empty event", q[utf_pkg::T_EMPTY_EVT], 1'b1);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_EMPTY_EVT), 4'hE);
    wb(1'b0, utf_pkg::ADR_TX, '0, 4'hF);
    chk("empty event once", q[utf_pkg::T_EMPTY_EVT], 1'b0);
  endtask
  task automatic s_cts();
    base = rx_count;
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_DELTA) | 32'h11, 4'hF);
    wb(1'b1, utf_pkg::ADR_TX, 32'h22, 4'hF);
    wait_low();
    cts_hold <= 1'b1;
    repeat (400) @(posedge clk);
    chk("chars while held", rx_count, base + 1);
    chk("finished char", rx_bits[7:0], 8'h11);
    wb(1'b0, utf_pkg::ADR_TX, '0, 4'hF);
    chk("cts level", q[utf_pkg::T_CTS], 1'b1);
    chk("cts change", q[utf_pkg::T_DELTA], 1'b1);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_DELTA), 4'hE);
    wb(1'b1, utf_pkg::ADR_CTRL, ctl | bit_at(utf_pkg::C_CTS_IE), 4'hF);
    chk("irq quiet", irq, 1'b0);
    cts_hold <= 1'b0;
    repeat (40) @(posedge clk);
    chk("irq on fall", irq, 1'b1);
    wait_rx(base + 2);
    chk("released char", rx_bits[7:0], 8'h22);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_DELTA), 4'hE);
    cts_hold <= 1'b1;
    repeat (40) @(posedge clk);
    chk("irq on rise", irq, 1'b1);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_DELTA), 4'hE);
    wb(1'b1, utf_pkg::ADR_CTRL, ctl, 4'hF);
  endtask
  // Fill while clear-to-send is negated, so nothing drains
  task automatic s_fill();
    base = rx_count;
    for (int i = 0; i < 65; i++)
      wb(1'b1, utf_pkg::ADR_TX, i, 4'hF);
    wb(1'b0, utf_pkg::ADR_LEVEL, '0, 4'hF);
    chk("fill count", q[22:16], utf_pkg::TX_FULL);
    wb(1'b0, utf_pkg::ADR_TX, '0, 4'hF);
    chk("slot free full", q[utf_pkg::T_AVAIL], 1'b0);
    wb(1'b1, utf_pkg::ADR_CTRL, ctl & ~bit_at(utf_pkg::C_TX_EN), 4'hF);
    wb(1'b0, utf_pkg::ADR_LEVEL, '0, 4'hF);
    chk("flushed", q[22:16], 7'h00);
    chk("none sent", rx_count, base);
    cts_hold <= 1'b0;
  endtask
  task automatic s_break();
    int bad;
    bad = 0;
    wb(1'b1, utf_pkg::ADR_CTRL, ctl, 4'hF);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_BRK), 4'hE);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_BRK) | 32'hFF, 4'hF);
    wait_low();
    for (int i = 0; i < 160; i++)
    begin
      @(posedge clk);
      bad += (txd !== 1'b0);
    end
    chk("break low", bad, 0);
    wb(1'b0, utf_pkg::ADR_TX, '0, 4'hF);
    for (int i = 0; i < 50 && q[utf_pkg::T_BUSY] !== 1'b0; i++)
      wb(1'b0, utf_pkg::ADR_TX, '0, 4'hF);
    chk("busy clears", q[utf_pkg::T_BUSY], 1'b0);
    wb(1'b1, utf_pkg::ADR_TX, '0, 4'hE);
    repeat (4) @(posedge clk);
    chk("idle after break", txd, 1'b1);
  endtask
  task automatic s_rts();
    for (int i = 0; i < 2; i++)
    begin
      wb(1'b1, utf_pkg::ADR_MISC, i << utf_pkg::M_RTSGP, 4'hF);
      repeat (4) @(posedge clk);
      chk("rts gp", rts_b, i[0]);
    end
    wb(1'b1, utf_pkg::ADR_MISC, bit_at(utf_pkg::M_RTSFLOW), 4'hF);
    for (int i = 0; i < 2; i++)
    begin
      rx_nearly_full <= i[0];
      repeat (4) @(posedge clk);
      chk("rts flow", rts_b, i);
    end
  endtask
  // Start, eight zero data bits and even parity give ten pulses
  task automatic s_irda();
    int hi;
    hi = 0;
    wb(1'b1, utf_pkg::ADR_MISC, '0, 4'hF);
    wb(1'b1, utf_pkg::ADR_CTRL, ctl | bit_at(utf_pkg::C_IRDA), 4'hF);
    repeat (20) @(posedge clk);
    chk("ir idle", txd, 1'b0);
    wb(1'b1, utf_pkg::ADR_TX, bit_at(utf_pkg::T_IGN), 4'hF);
    for (int i = 0; i < 220; i++)
    begin
      @(posedge clk);
      hi += (txd === 1'b1);
    end
    chk("ir pulse cycles", hi, 30);
    wb(1'b1, utf_pkg::ADR_MISC, bit_at(utf_pkg::M_TX_POL), 4'hF);
    repeat (4) @(posedge clk);
    chk("ir idle inverted", txd, 1'b1);
  endtask
  // Pin ticks alone move the bit clock; the pin is released a cycle after it starts feeding the divider
  task automatic s_clk();
    logic was;
    wb(1'b1, utf_pkg::ADR_MISC, bit_at(utf_pkg::M_RX_POL), 4'hF);
    chk("rx polarity", rx_pol, 1'b1);
    wb(1'b1, utf_pkg::ADR_CTRL, ctl | bit_at(utf_pkg::C_CLK_OUT), 4'hF);
    chk("clock pin driven", ucl_oe_b, 1'b0);
    wb(1'b1, utf_pkg::ADR_CTRL, ctl | bit_at(utf_pkg::C_CLK_OUT) |
      bit_at(utf_pkg::C_BAUD_EXT), 4'hF);
    chk("clock pin input", ucl_oe_b, 1'b1);
    was = ucl_out;
    for (int i = 0; i < 16; i++)
    begin
      ucl_in <= ~ucl_in;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    chk("bit clock from pin", ucl_out, !was);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    ctl = bit_at(utf_pkg::C_PORT_EN) | bit_at(utf_pkg::C_TX_EN) |
      bit_at(utf_pkg::C_PAR_EN) | bit_at(utf_pkg::C_CHAR8);
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    s_reset();
    s_frame();
    s_cts();
    s_fill();
    s_break();
    s_rts();
    s_irda();
    s_clk();
    print_verdict();
  end
  initial
  begin
    repeat (100000) @(posedge clk);
    hang();
  end
endmodule
`default_nettype wire
